/* dv/fiosc_cmd_tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin error_cnt++; \
    $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
// ****************************************************************
// Bench top for the command slice
// ****************************************************************
module fiosc_cmd_tb_top;
    localparam logic [7:0] SIG = 8'h3C;
    localparam logic [7:0] MKR = 8'hA7;
    localparam logic [7:0] DEV = 8'h4E;
    localparam logic [7:0] DPD = 8'hF3;
    localparam logic [7:0] SWR = 8'hF2;
    logic sys_clk, rst_n, cs_n, sclk, sio0, sio1_out, sio1_oe, write_latch;
    logic lock_program, cmd_pass, cmd_reject, otp_mode, deep_pd, standby;
    logic fl_nv, cl_nv;
    logic [2:0] upper;
    logic [7:0] cmd_opcode, sec_byte, exp_sec, v;
    logic [7:0] tx [8];
    logic [7:0] rx [8];
    logic [7:0] bad [6] = '{8'hD8, 8'h52, 8'h60, 8'hC7, 8'hE0, 8'hF1};
    logic [7:0] corner [4] = '{8'hC0, 8'h08, 8'h08, 8'h0C};
    logic [31:0] seed = 32'hE073;
    fiosc_pkg::fiosc_evt_t evt;
    int error_cnt = 0, comparisons = 0, rej_cnt = 0, pass_cnt = 0, lock_cnt = 0;
    int oe_cnt = 0, wake_cyc = 0, r0, o0;

    // Bench clock of 100 ns.
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    fiosc_cmd #(.SIGNATURE_ID(SIG), .MAKER_ID(MKR), .DEVICE_ID(DEV), .OPC_SECTOR_ERASE(8'hE0),
        .OPC_STATUS_WRITE(8'hF1), .OPC_SECURITY_WRITE(SWR), .OPC_DEEP_PD(DPD)) u_dut (
        .SYS_CLK(sys_clk), .RST_N(rst_n), .CS_N(cs_n), .SCLK(sclk), .SIO0_IN(sio0),
        .UPPER_DATA_LINES_IN(upper), .SIO1_OUT(sio1_out), .SIO1_OE(sio1_oe), .ENGINE_EVT(evt),
        .WRITE_LATCH(write_latch), .FACTORY_LOCK_NV(fl_nv), .CUSTOMER_LOCK_NV(cl_nv),
        .LOCK_PROGRAM(lock_program), .CMD_PASS(cmd_pass), .CMD_REJECT(cmd_reject),
        .CMD_OPCODE(cmd_opcode), .OTP_MODE(otp_mode), .DEEP_POWER_DOWN(deep_pd),
        .STANDBY(standby), .SECURITY_BYTE(sec_byte));

    fiosc_host_model u_host (.sys_clk(sys_clk), .cs_n(cs_n), .sclk(sclk), .sio0(sio0),
        .upper(upper), .sio1_out(sio1_out), .sio1_oe(sio1_oe));

    // Pulse and state counters; pulses last one cycle, so every edge is looked at.
    always @(posedge sys_clk) begin
        if (cmd_reject === 1'b1) rej_cnt++;
        if (cmd_pass === 1'b1) pass_cnt++;
        if (lock_program === 1'b1) lock_cnt++;
        if (sio1_oe === 1'b1) oe_cnt++;
        if (deep_pd === 1'b0 && standby === 1'b0) wake_cyc++;
    end

    // Repeatable random source.
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // Expected security flags after one engine pulse vector; set wins over clear.
    function automatic logic [7:0] upd(logic [7:0] c, fiosc_pkg::fiosc_evt_t e);
        if (e.prog_resume) c[2] = 1'b0;
        if (e.prog_suspend) c[2] = 1'b1;
        if (e.erase_resume) c[3] = 1'b0;
        if (e.erase_suspend) c[3] = 1'b1;
        if (e.prog_done) c[5] = ~e.prog_ok;
        if (e.erase_done) c[6] = ~e.erase_ok;
        return c;
    endfunction : upd

    // One frame with an opcode and an address in the fourth byte.
    task automatic run(input logic [7:0] op, input logic [7:0] a, input int n);
        tx = '{default: 8'h00};
        tx[0] = op;
        tx[3] = a;
        u_host.frame(tx, n, rx);
    endtask : run

    // Keeps select high until standby returns; the bound catches a hang.
    task automatic wait_standby();
        int t;
        t = 0;
        while (standby !== 1'b1 && t < 300) begin
            @(posedge sys_clk);
            t++;
        end
        if (t >= 300) begin
            error_cnt++;
            close_out();
        end
        @(negedge sys_clk);
    endtask : wait_standby

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out

    // Main sequence.
    initial begin
        rst_n = 1'b0;
        write_latch = 1'b0;
        fl_nv = 1'b0;
        cl_nv = 1'b0;
        evt = '0;
        exp_sec = 8'h00;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(negedge sys_clk);
        `CHK("security reset", exp_sec, sec_byte)
        for (int k = 0; k < 24; k++) begin
            v = (k < 4) ? corner[k] : rnd();
            exp_sec = upd(exp_sec, v);
            @(posedge sys_clk) evt <= v;
            @(posedge sys_clk) evt <= '0;
            @(negedge sys_clk);
            `CHK("security flags", exp_sec, sec_byte)
        end
        $display("test security done");
        run(fiosc_pkg::OPC_SEC_READ, 8'h00, 3);
        `CHK("security read a", exp_sec, rx[1])
        `CHK("security read b", exp_sec, rx[2])
        run(fiosc_pkg::OPC_RELEASE_SIG, 8'h00, 6);
        `CHK("signature a", SIG, rx[4])
        `CHK("signature b", SIG, rx[5])
        `CHK("standby after release", 1'b1, standby)
        for (int a = 0; a < 2; a++) begin
            run(fiosc_pkg::OPC_MAKER_DEV_ID, a[7:0], 7);
            `CHK("first id", a ? DEV : MKR, rx[4])
            `CHK("second id", a ? MKR : DEV, rx[5])
            `CHK("third id", a ? DEV : MKR, rx[6])
        end
        $display("test identifiers done");
        run(DPD, 8'h00, 1);
        `CHK("deep entered", 1'b1, deep_pd)
        o0 = oe_cnt;
        run(fiosc_pkg::OPC_SEC_READ, 8'h00, 3);
        run(fiosc_pkg::OPC_ENTER_OTP, 8'h00, 1);
        `CHK("silent in deep", o0, oe_cnt)
        `CHK("no otp in deep", 1'b0, otp_mode)
        @(negedge sys_clk) wake_cyc = 0;
        run(fiosc_pkg::OPC_RELEASE_SIG, 8'h00, 1);
        wait_standby();
        `CHK("wake one", 1'b1, wake_cyc >= 29 && wake_cyc <= 31)
        run(DPD, 8'h00, 1);
        @(negedge sys_clk) wake_cyc = 0;
        run(fiosc_pkg::OPC_RELEASE_SIG, 8'h00, 5);
        wait_standby();
        `CHK("signature from deep", SIG, rx[4])
        `CHK("wake two", 1'b1, wake_cyc >= 87 && wake_cyc <= 89)
        $display("test power down done");
        run(fiosc_pkg::OPC_ENTER_OTP, 8'h00, 1);
        `CHK("otp entered", 1'b1, otp_mode)
        for (int i = 0; i < 7; i++) begin
            r0 = rej_cnt;
            run(i < 6 ? bad[i] : SWR, 8'h00, 1);
            `CHK("otp screen", r0 + 1, rej_cnt)
        end
        r0 = pass_cnt;
        run(fiosc_pkg::OPC_READ, 8'h00, 4);
        `CHK("otp read passes", r0 + 1, pass_cnt)
        `CHK("passed opcode", fiosc_pkg::OPC_READ, cmd_opcode)
        // With no lock set yet, a program into the one-time area must still pass.
        r0 = pass_cnt;
        run(8'h02, 8'h00, 4);
        `CHK("unlocked program passes", r0 + 1, pass_cnt)
        run(fiosc_pkg::OPC_EXIT_OTP, 8'h00, 1);
        `CHK("otp left", 1'b0, otp_mode)
        @(posedge sys_clk) write_latch <= 1'b1;
        run(SWR, 8'h00, 1);
        run(SWR, 8'h00, 1);
        `CHK("lock once", 1, lock_cnt)
        `CHK("lock bit", 1'b1, sec_byte[1])
        @(posedge sys_clk) write_latch <= 1'b0;
        run(fiosc_pkg::OPC_ENTER_OTP, 8'h00, 1);
        r0 = rej_cnt;
        run(8'h02, 8'h00, 4);
        `CHK("locked program refused", r0 + 1, rej_cnt)
        // Reset in mid-run while the one-time area is mapped in, both locks now set.
        @(posedge sys_clk) begin
            rst_n <= 1'b0;
            fl_nv <= 1'b1;
            cl_nv <= 1'b1;
        end
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(negedge sys_clk);
        `CHK("security after reset", 8'h03, sec_byte)
        `CHK("otp cleared by reset", 1'b0, otp_mode)
        `CHK("standby after reset", 1'b1, standby)
        $display("test reset done");
        run(fiosc_pkg::OPC_EXIT_OTP, 8'h00, 1);
        $display("test otp done");
        close_out();
    end
endmodule : fiosc_cmd_tb_top

/* dv/fiosc_host_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// Host serial controller, mode 0, link clock of 800 ns
// ****************************************************************
module fiosc_host_model (
    // Bench clock.
    input wire logic sys_clk,
    // Serial pins toward the device.
    output logic cs_n,
    output logic sclk,
    output logic sio0,
    output logic [2:0] upper,
    input wire logic sio1_out,
    input wire logic sio1_oe
);
    logic last_line;
    logic line;

    // An undriven data line shows the inverse of its last level, so stale data never passes.
    assign line = sio1_oe ? sio1_out : ~last_line;

    // Idle levels; the link clock stands low outside frames.
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sio0 = 1'b0;
        upper = 3'h5;
        last_line = 1'b0;
    end

    // The upper lines carry a pattern that moves every cycle, so the device must ignore them.
    always @(posedge sys_clk) upper <= ~upper ^ {upper[1:0], upper[2]};

    // One whole frame: bytes go out MSB first on rising edges, replies are taken before each rise.
    task automatic frame(input logic [7:0] tx [8], input int n, output logic [7:0] rx [8]);
        logic [7:0] acc;
        @(posedge sys_clk);
        cs_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        for (int i = 0; i < n; i++) begin
            for (int b = 7; b >= 0; b--) begin
                sio0 <= tx[i][b];
                repeat (4) @(posedge sys_clk);
                @(negedge sys_clk);
                acc[b] = line;
                last_line = line;
                @(posedge sys_clk);
                sclk <= 1'b1;
                // High for three cycles and low for five: an 800 ns link clock.
                repeat (3) @(posedge sys_clk);
                sclk <= 1'b0;
            end
            rx[i] = acc;
        end
        repeat (8) @(posedge sys_clk);
        cs_n <= 1'b1;
        sio0 <= ~sio0;
        repeat (8) @(posedge sys_clk);
    endtask : frame
endmodule : fiosc_host_model

/* rtl/fiosc_cmd.sv */
`timescale 1ns/1ps
module fiosc_cmd #(
    parameter logic [7:0] SIGNATURE_ID = 8'h3C,
    parameter logic [7:0] MAKER_ID = 8'hA7,
    parameter logic [7:0] DEVICE_ID = 8'h4E,
    parameter logic [7:0] OPC_SECTOR_ERASE = 8'hE0,
    parameter logic [7:0] OPC_STATUS_WRITE = 8'hF1,
    parameter logic [7:0] OPC_SECURITY_WRITE = 8'hF2,
    parameter logic [7:0] OPC_DEEP_PD = 8'hF3
) (
    // Clock and reset.
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // Serial pins from the host.
    input wire logic CS_N,
    input wire logic SCLK,
    input wire logic SIO0_IN,
    input wire logic [2:0] UPPER_DATA_LINES_IN,
    output logic SIO1_OUT,
    output logic SIO1_OE,
    // Program and erase engine.
    input wire fiosc_pkg::fiosc_evt_t ENGINE_EVT,
    input wire logic WRITE_LATCH,
    input wire logic FACTORY_LOCK_NV,
    input wire logic CUSTOMER_LOCK_NV,
    output logic LOCK_PROGRAM,
    // Command hand-off to the rest of the device.
    output logic CMD_PASS,
    output logic CMD_REJECT,
    output logic [7:0] CMD_OPCODE,
    // Mode and state.
    output logic OTP_MODE,
    output logic DEEP_POWER_DOWN,
    output logic STANDBY,
    output logic [7:0] SECURITY_BYTE
);

    // ****************************************************************
    // Pin synchronisers and edge detection
    // ****************************************************************
    logic cs_s1, cs_s2, cs_d, sck_s1, sck_s2, sck_d, si_s1, si_s2;

    // Two synchroniser flops per pin and a third on select and clock; edges are taken from the second and third stage only.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            {cs_s1, cs_s2, cs_d} <= 3'h7;
            {sck_s1, sck_s2, sck_d, si_s1, si_s2} <= 5'h00;
        end else begin
            {cs_s1, cs_s2, cs_d} <= {CS_N, cs_s1, cs_s2};
            {sck_s1, sck_s2, sck_d} <= {SCLK, sck_s1, sck_s2};
            {si_s1, si_s2} <= {SIO0_IN, si_s1};
        end
    end

    // The upper data lines are never sampled: they are don't-care here.
    wire cs_fall = cs_d & ~cs_s2;
    wire cs_rise = ~cs_d & cs_s2;
    wire sck_rise = ~sck_d & sck_s2 & ~cs_s2;
    wire sck_fall = sck_d & ~sck_s2 & ~cs_s2;

    // ****************************************************************
    // Frame shifter
    // ****************************************************************
    logic [2:0] bit_idx, byte_cnt;
    logic [6:0] shreg;
    logic [7:0] opcode;
    logic addr_lsb, id_sel;
    fiosc_pkg::fiosc_pwr_t pwr, next_pwr;
    fiosc_pkg::fiosc_scur_t scur;

    // Header length before output starts; zero means the command is silent.
    // The identifier read counts opcode, two dummies and the address byte.
    function automatic logic [2:0] hdr_bytes(input logic [7:0] op);
        hdr_bytes = 3'h0;
        if (op == fiosc_pkg::OPC_RELEASE_SIG) hdr_bytes = fiosc_pkg::SIG_HDR_BYTES;
        if (op == fiosc_pkg::OPC_MAKER_DEV_ID) hdr_bytes = fiosc_pkg::ID_HDR_BYTES;
        if (op == fiosc_pkg::OPC_SEC_READ) hdr_bytes = fiosc_pkg::SEC_HDR_BYTES;
    endfunction : hdr_bytes

    // Commands that must not run while the one-time area is mapped in.
    function automatic logic otp_blocked(input logic [7:0] op);
        otp_blocked = (op == OPC_STATUS_WRITE) || (op == OPC_SECURITY_WRITE) ||
            (op == OPC_SECTOR_ERASE) || (op == fiosc_pkg::OPC_BLOCK64_ERASE) ||
            (op == fiosc_pkg::OPC_BLOCK32_ERASE) || (op == fiosc_pkg::OPC_CHIP_ERASE_A) ||
            (op == fiosc_pkg::OPC_CHIP_ERASE_B);
    endfunction : otp_blocked

    // Commands still legal after the one-time area is locked.
    function automatic logic read_type(input logic [7:0] op);
        read_type = (op == fiosc_pkg::OPC_READ) || (op == fiosc_pkg::OPC_FAST_READ) ||
            (op == fiosc_pkg::OPC_DUAL_READ) || (op == fiosc_pkg::OPC_QUAD_READ) ||
            (op == fiosc_pkg::OPC_DUAL_IO_READ) || (op == fiosc_pkg::OPC_QUAD_IO_READ) ||
            (op == fiosc_pkg::OPC_SFDP_READ) || (op == fiosc_pkg::OPC_JEDEC_ID_READ) ||
            (op == fiosc_pkg::OPC_STATUS_READ) || (op == fiosc_pkg::OPC_SEC_READ) ||
            (op == fiosc_pkg::OPC_MAKER_DEV_ID) || (op == fiosc_pkg::OPC_RELEASE_SIG) ||
            (op == fiosc_pkg::OPC_EXIT_OTP);
    endfunction : read_type

    // Only the release opcode may talk in deep power-down; nothing while waking.
    wire [2:0] hdr = hdr_bytes(opcode);
    wire talk_ok = (pwr == fiosc_pkg::PWR_STANDBY) ||
        (pwr == fiosc_pkg::PWR_DEEP && opcode == fiosc_pkg::OPC_RELEASE_SIG);
    wire out_active = talk_ok && (hdr != 3'h0) && (byte_cnt >= hdr);
    wire whole = (bit_idx == 3'h0) && (byte_cnt != 3'h0);
    wire only_op = whole && (byte_cnt == 3'h1);

    // Rising edges shift in; the byte count saturates so long reads keep going.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || cs_fall) begin
            {bit_idx, byte_cnt, shreg, opcode, addr_lsb, id_sel} <= 23'h000000;
        end else if (sck_rise) begin
            bit_idx <= bit_idx + 3'h1;
            shreg <= {shreg[5:0], si_s2};
            if (bit_idx == 3'h7) begin
                byte_cnt <= (byte_cnt == 3'h7) ? byte_cnt : byte_cnt + 3'h1;
                if (byte_cnt == 3'h0) opcode <= {shreg, si_s2};
                if (byte_cnt == 3'h3) addr_lsb <= si_s2;
                if (out_active) id_sel <= ~id_sel;
            end
        end
    end

    // ****************************************************************
    // Serial output
    // ****************************************************************
    logic [7:0] cur_byte;

    // The identifier pair alternates; the address LSB picks which comes first.
    always_comb begin
        cur_byte = 8'h00;
        case (opcode)
            fiosc_pkg::OPC_RELEASE_SIG: cur_byte = SIGNATURE_ID;
            fiosc_pkg::OPC_SEC_READ: cur_byte = scur;
            fiosc_pkg::OPC_MAKER_DEV_ID: cur_byte = (id_sel ^ addr_lsb) ? DEVICE_ID : MAKER_ID;
            default: cur_byte = 8'h00;
        endcase
    end

    // Data changes on the falling edge so the host samples a stable bit.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N || cs_fall || cs_rise) begin
            SIO1_OUT <= 1'b0;
            SIO1_OE <= 1'b0;
        end else if (sck_fall && out_active) begin
            SIO1_OUT <= cur_byte[~bit_idx];
            SIO1_OE <= 1'b1;
        end
    end

    // ****************************************************************
    // Power state
    // ****************************************************************
    logic [11:0] wake_cnt;
    wire release_cmd = cs_rise && whole && (opcode == fiosc_pkg::OPC_RELEASE_SIG);

    // Opcode-only release uses the first delay, any longer release frame the second.
    always_comb begin
        next_pwr = pwr;
        case (pwr)
            fiosc_pkg::PWR_DEEP: if (release_cmd) next_pwr = fiosc_pkg::PWR_WAKING;
            fiosc_pkg::PWR_WAKING: if (wake_cnt == 12'h000) next_pwr = fiosc_pkg::PWR_STANDBY;
            fiosc_pkg::PWR_STANDBY: begin
                if (cs_rise && only_op && opcode == OPC_DEEP_PD) next_pwr = fiosc_pkg::PWR_DEEP;
            end
            default: next_pwr = fiosc_pkg::PWR_STANDBY;
        endcase
    end

    // Frames that arrive while waking are dropped, so the host must wait.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            pwr <= fiosc_pkg::PWR_STANDBY;
            wake_cnt <= 12'h000;
        end else begin
            pwr <= next_pwr;
            if (pwr == fiosc_pkg::PWR_DEEP && release_cmd) begin
                wake_cnt <= (byte_cnt == 3'h1) ? 12'(fiosc_pkg::RELEASE_ONE_CYC - 1)
                    : 12'(fiosc_pkg::RELEASE_TWO_CYC - 1);
            end else if (wake_cnt != 12'h000) begin
                wake_cnt <= wake_cnt - 12'h001;
            end
        end
    end

    // ****************************************************************
    // Command screening and mode
    // ****************************************************************
    wire otp_locked = scur.customer_otp_lock | scur.factory_lock;
    wire frame_end = cs_rise && (byte_cnt != 3'h0) && (pwr == fiosc_pkg::PWR_STANDBY);
    wire local_cmd = (opcode == fiosc_pkg::OPC_RELEASE_SIG) ||
        (opcode == fiosc_pkg::OPC_MAKER_DEV_ID) || (opcode == fiosc_pkg::OPC_SEC_READ) ||
        (opcode == fiosc_pkg::OPC_ENTER_OTP) || (opcode == fiosc_pkg::OPC_EXIT_OTP) ||
        (opcode == OPC_DEEP_PD) || (opcode == OPC_SECURITY_WRITE);
    wire reject = OTP_MODE && (otp_blocked(opcode) || (otp_locked && !read_type(opcode)));
    wire lock_req = frame_end && only_op && (opcode == OPC_SECURITY_WRITE) && !reject &&
        WRITE_LATCH && !scur.customer_otp_lock;

    // Release and signature never reach the engine, so a running cycle is untouched.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            {CMD_PASS, CMD_REJECT, LOCK_PROGRAM, OTP_MODE} <= 4'h0;
            CMD_OPCODE <= 8'h00;
        end else begin
            CMD_PASS <= frame_end && !local_cmd && !reject;
            CMD_REJECT <= frame_end && reject;
            LOCK_PROGRAM <= lock_req;
            if (frame_end) CMD_OPCODE <= opcode;
            if (frame_end && only_op && opcode == fiosc_pkg::OPC_ENTER_OTP) OTP_MODE <= 1'b1;
            if (frame_end && only_op && opcode == fiosc_pkg::OPC_EXIT_OTP) OTP_MODE <= 1'b0;
        end
    end

    // ****************************************************************
    // Security byte
    // ****************************************************************
    logic init_done;

    // Non-volatile bits are copied in the cycle after reset release; set wins over clear.
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            scur <= fiosc_pkg::SCUR_RESET;
            init_done <= 1'b0;
        end else begin
            init_done <= 1'b1;
            if (!init_done) scur.factory_lock <= FACTORY_LOCK_NV;
            scur.customer_otp_lock <= scur.customer_otp_lock | lock_req |
                (!init_done & CUSTOMER_LOCK_NV);
            scur.program_suspended_flag <= ENGINE_EVT.prog_suspend |
                (scur.program_suspended_flag & ~ENGINE_EVT.prog_resume);
            scur.erase_suspended_flag <= ENGINE_EVT.erase_suspend |
                (scur.erase_suspended_flag & ~ENGINE_EVT.erase_resume);
            scur.prog_fail <= (ENGINE_EVT.prog_done & ~ENGINE_EVT.prog_ok) |
                (scur.prog_fail & ~(ENGINE_EVT.prog_done & ENGINE_EVT.prog_ok));
            scur.erase_fail <= (ENGINE_EVT.erase_done & ~ENGINE_EVT.erase_ok) |
                (scur.erase_fail & ~(ENGINE_EVT.erase_done & ENGINE_EVT.erase_ok));
        end
    end

    // State outputs are decoded from flops.
    assign DEEP_POWER_DOWN = (pwr == fiosc_pkg::PWR_DEEP);
    assign STANDBY = (pwr == fiosc_pkg::PWR_STANDBY);
    assign SECURITY_BYTE = scur;

    // ****************************************************************
    // Checks
    // ****************************************************************
    localparam int WAKE_ONE = fiosc_pkg::RELEASE_ONE_CYC;
    localparam int WAKE_TWO = fiosc_pkg::RELEASE_TWO_CYC;

    chk_wake_delay_one: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (pwr == fiosc_pkg::PWR_DEEP && release_cmd && byte_cnt == 3'h1)
        |-> ##WAKE_ONE (pwr == fiosc_pkg::PWR_WAKING) ##1 (pwr == fiosc_pkg::PWR_STANDBY))
        else $error("first release delay wrong");
    chk_wake_delay_two: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (pwr == fiosc_pkg::PWR_DEEP && release_cmd && byte_cnt > 3'h1)
        |-> ##WAKE_TWO (pwr == fiosc_pkg::PWR_WAKING) ##1 (pwr == fiosc_pkg::PWR_STANDBY))
        else $error("second release delay wrong");
    chk_standby_stays: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (STANDBY && release_cmd) |=> STANDBY)
        else $error("release left standby");
    chk_deep_ignores: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (pwr != fiosc_pkg::PWR_STANDBY && cs_rise) |=> !CMD_PASS && !$changed(OTP_MODE))
        else $error("command acted outside standby");
    chk_otp_enter: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (frame_end && only_op && opcode == fiosc_pkg::OPC_ENTER_OTP) |=> OTP_MODE)
        else $error("enter otp missed");
    chk_otp_exit: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (frame_end && only_op && opcode == fiosc_pkg::OPC_EXIT_OTP) |=> !OTP_MODE)
        else $error("exit otp missed");
    chk_otp_reject: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (frame_end && OTP_MODE && otp_blocked(opcode)) |=> CMD_REJECT && !CMD_PASS)
        else $error("blocked command passed in otp mode");
    chk_psb_follow: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        ENGINE_EVT.prog_suspend |=> scur.program_suspended_flag [*2] or ENGINE_EVT.prog_resume)
        else $error("program suspend flag not set");
    chk_pfail_sticky: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (scur.prog_fail && !(ENGINE_EVT.prog_done && ENGINE_EVT.prog_ok)) |=> scur.prog_fail)
        else $error("program fail flag dropped");
    chk_lock_sticky: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        scur.customer_otp_lock |=> scur.customer_otp_lock && !LOCK_PROGRAM)
        else $error("customer lock changed");
    chk_id_first: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (sck_fall && out_active && opcode == fiosc_pkg::OPC_MAKER_DEV_ID && bit_idx == 3'h0 &&
        id_sel == 1'b0) |=> SIO1_OE && SIO1_OUT == (addr_lsb ? DEVICE_ID[7] : MAKER_ID[7]))
        else $error("identifier order wrong");

endmodule : fiosc_cmd

/* rtl/fiosc_pkg.sv */
package fiosc_pkg;

    // ****************************************************************
    // Opcodes handled or screened by the command slice
    // ****************************************************************
    localparam logic [7:0] OPC_RELEASE_SIG = 8'hAB;
    localparam logic [7:0] OPC_MAKER_DEV_ID = 8'h90;
    localparam logic [7:0] OPC_ENTER_OTP = 8'hB1;
    localparam logic [7:0] OPC_EXIT_OTP = 8'hC1;
    localparam logic [7:0] OPC_SEC_READ = 8'h2B;
    localparam logic [7:0] OPC_BLOCK64_ERASE = 8'hD8;
    localparam logic [7:0] OPC_BLOCK32_ERASE = 8'h52;
    localparam logic [7:0] OPC_CHIP_ERASE_A = 8'h60;
    localparam logic [7:0] OPC_CHIP_ERASE_B = 8'hC7;
    // Read-type opcodes that stay legal once the one-time area is locked.
    localparam logic [7:0] OPC_READ = 8'h03;
    localparam logic [7:0] OPC_FAST_READ = 8'h0B;
    localparam logic [7:0] OPC_DUAL_READ = 8'h3B;
    localparam logic [7:0] OPC_QUAD_READ = 8'h6B;
    localparam logic [7:0] OPC_DUAL_IO_READ = 8'hBB;
    localparam logic [7:0] OPC_QUAD_IO_READ = 8'hEB;
    localparam logic [7:0] OPC_SFDP_READ = 8'h5A;
    localparam logic [7:0] OPC_JEDEC_ID_READ = 8'h9F;
    localparam logic [7:0] OPC_STATUS_READ = 8'h05;

    // ****************************************************************
    // Frame layout: bytes clocked in before the device starts talking
    // ****************************************************************
    localparam logic [2:0] SIG_HDR_BYTES = 3'h4;
    localparam logic [2:0] ID_HDR_BYTES = 3'h4;
    localparam logic [2:0] SEC_HDR_BYTES = 3'h1;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int SYS_CLK_MHZ = 10;
    localparam int RELEASE_DELAY_ONE_NS = 3000;
    localparam int RELEASE_DELAY_TWO_NS = 8800;
    localparam int RELEASE_ONE_CYC = (RELEASE_DELAY_ONE_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int RELEASE_TWO_CYC = (RELEASE_DELAY_TWO_NS * SYS_CLK_MHZ + 999) / 1000;

    // ****************************************************************
    // Security byte layout, bit 7 down to bit 0
    // ****************************************************************
    typedef struct packed {
        logic rsv7;
        logic erase_fail;
        logic prog_fail;
        logic rsv4;
        logic erase_suspended_flag;
        logic program_suspended_flag;
        logic customer_otp_lock;
        logic factory_lock;
    } fiosc_scur_t;
    localparam fiosc_scur_t SCUR_RESET = 8'h00;

    // Event pulses from the program and erase engine.
    typedef struct packed {
        logic prog_suspend;
        logic prog_resume;
        logic erase_suspend;
        logic erase_resume;
        logic prog_done;
        logic prog_ok;
        logic erase_done;
        logic erase_ok;
    } fiosc_evt_t;

    typedef enum logic [1:0] {PWR_STANDBY, PWR_DEEP, PWR_WAKING} fiosc_pwr_t;

endpackage : fiosc_pkg
